//--- logic/brg_map.svh
// register offsets, field positions and reset values of the rate generator
// assumes: included by the rate generator module and its testbench only
`ifndef BRG_MAP_SVH
`define BRG_MAP_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define BRG_OFF_BAUD_CTRL 3'h0
`define BRG_OFF_RX_STAT 3'h1
`define BRG_OFF_DIV_LOW 3'h2
`define BRG_OFF_DIV_HIGH 3'h3
`define BRG_OFF_TX_STAT 3'h4

// ----------------------------------------
// field positions
// ----------------------------------------
`define BRG_BIT_RX_IDLE 6
`define BRG_BIT_WIDE 3
`define BRG_BIT_SYNC 4
`define BRG_BIT_HSPEED 2
`define BRG_BIT_TX_EMPTY 1

// ----------------------------------------
// reset values and writable masks
// ----------------------------------------
`define BRG_RST_BYTE 8'h00
`define BRG_MASK_BAUD 8'h9B
`define BRG_MASK_TX 8'hFD

// ----------------------------------------
// clock multipliers of the divisor period
// ----------------------------------------
`define BRG_MULT_SLOW 7'h40
`define BRG_MULT_MID 7'h10
`define BRG_MULT_FAST 7'h04

`endif

//--- logic/brg_pkg.sv
// types shared by the rate generator
// assumes: the map header is on the include path
package brg_pkg;
   typedef logic [2:0] brg_addr_t;
   typedef logic [7:0] brg_byte_t;
   typedef logic [15:0] brg_div_t;
   typedef logic [6:0] brg_mult_t;
   typedef logic [22:0] brg_span_t;
endpackage : brg_pkg

//--- logic/brg_rate_gen.sv
// serial port rate timer with its control and divisor registers
// assumes: one 125 MHz clock; receiver and transmitter flags on the same clock
//
// What this block does
// [RULE1] one rate timer, 8 or 16 bits wide, paces async and sync serial work
// [RULE2] after reset the timer runs 8 bits wide
// [RULE3] wide divider select set makes the timer use all 16 bits
// [RULE4] divisor low gives bits 7..0, divisor high bits 15..8; timer free runs
// [RULE5] async multiplier depends on high speed select and wide divider select
// [RULE6] sync mode ignores high speed select
// [RULE7] writing either divisor register clears the timer at once
// [RULE8] rates: 8-bit async 64(n+1), 16-bit async 16(n+1), sync 4(n+1)
// [RULE9] software checks receive idle flag before changing the system clock
// [RULE10] software picks high speed or wide mode to cut rate error
// [RULE11] async high speed: 8-bit 16(n+1), 16-bit 4(n+1)
// [RULE12] each period end reloads the timer and gives a one-cycle tick
`timescale 1ns/1ps
`include "brg_map.svh"

module brg_rate_gen
   import brg_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // register port
   input wire brg_addr_t reg_addr,
   input wire brg_byte_t reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output brg_byte_t reg_rdata,
   // flags from the receiver and transmitter
   input wire logic rx_idle,
   input wire logic tx_empty,
   // to the receiver and transmitter
   output logic baud_tick,
   output logic sync_mode
);

   // ----------------------------------------
   // helpers
   // ----------------------------------------

   // clock multiplier for the current mode
   function automatic brg_mult_t mult_f(input logic sync, input logic wide, input logic hs);
      brg_mult_t m;
      m = `BRG_MULT_FAST;
      if (sync)
         m = `BRG_MULT_FAST; // [RULE6] [RULE8]
      else if (!wide && !hs)
         m = `BRG_MULT_SLOW; // [RULE5] [RULE8]
      else if (wide && hs)
         m = `BRG_MULT_FAST; // [RULE11]
      else
         m = `BRG_MULT_MID; // [RULE8] [RULE11]
      return m;
   endfunction : mult_f

   // divisor the timer really counts to; narrow mode sees the low byte only
   function automatic brg_div_t eff_div_f(input logic wide_sel, input brg_div_t div);
      return wide_sel ? div : {8'h00, div[7:0]};
   endfunction : eff_div_f

   // ----------------------------------------
   // registers
   // ----------------------------------------
   brg_byte_t baud_ctrl_ff;
   brg_byte_t rx_stat_ff;
   brg_byte_t tx_stat_ff;
   brg_byte_t div_low_ff;
   brg_byte_t div_high_ff;
   brg_byte_t reg_rdata_ff;
   brg_byte_t nxt_rdata;
   brg_div_t timer_ff;
   brg_mult_t pre_ff;
   logic tick_ff;

   logic wide;
   logic hs;
   logic sync;
   logic div_wr;
   logic pre_end;
   logic timer_end;
   brg_div_t divisor;
   brg_mult_t mult;

   // decoded control bits
   assign wide = baud_ctrl_ff[`BRG_BIT_WIDE];
   assign hs = tx_stat_ff[`BRG_BIT_HSPEED];
   assign sync = tx_stat_ff[`BRG_BIT_SYNC];
   assign mult = mult_f(sync, wide, hs);
   assign divisor = {div_high_ff, div_low_ff}; // [RULE4]
   assign div_wr = reg_wr && (reg_addr == `BRG_OFF_DIV_LOW || reg_addr == `BRG_OFF_DIV_HIGH);

   // baud control: wide select resets low, so 8-bit operation by default
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         baud_ctrl_ff <= `BRG_RST_BYTE; // [RULE2]
      else if (reg_wr && reg_addr == `BRG_OFF_BAUD_CTRL)
         baud_ctrl_ff <= reg_wdata & `BRG_MASK_BAUD; // [RULE3]
   end

   // receive status: plain storage for the receiver's settings
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         rx_stat_ff <= `BRG_RST_BYTE;
      else if (reg_wr && reg_addr == `BRG_OFF_RX_STAT)
         rx_stat_ff <= reg_wdata;
   end

   // transmit status: sync and high speed select live here
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         tx_stat_ff <= `BRG_RST_BYTE;
      else if (reg_wr && reg_addr == `BRG_OFF_TX_STAT)
         tx_stat_ff <= reg_wdata & `BRG_MASK_TX;
   end

   // divisor pair
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         div_low_ff <= `BRG_RST_BYTE;
         div_high_ff <= `BRG_RST_BYTE;
      end
      else if (reg_wr)
      begin
         if (reg_addr == `BRG_OFF_DIV_LOW)
            div_low_ff <= reg_wdata; // [RULE4]
         if (reg_addr == `BRG_OFF_DIV_HIGH)
            div_high_ff <= reg_wdata; // [RULE4]
      end
   end

   // ----------------------------------------
   // read port
   // ----------------------------------------

   // read mux; the idle and empty flags are live, not stored
   always_comb
   begin
      nxt_rdata = `BRG_RST_BYTE;
      unique case (reg_addr)
         `BRG_OFF_BAUD_CTRL:
         begin
            nxt_rdata = baud_ctrl_ff;
            nxt_rdata[`BRG_BIT_RX_IDLE] = rx_idle;
         end
         `BRG_OFF_RX_STAT: nxt_rdata = rx_stat_ff;
         `BRG_OFF_DIV_LOW: nxt_rdata = div_low_ff;
         `BRG_OFF_DIV_HIGH: nxt_rdata = div_high_ff;
         `BRG_OFF_TX_STAT:
         begin
            nxt_rdata = tx_stat_ff;
            nxt_rdata[`BRG_BIT_TX_EMPTY] = tx_empty;
         end
         default: nxt_rdata = `BRG_RST_BYTE; // unmapped reads as zero
      endcase
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         reg_rdata_ff <= `BRG_RST_BYTE;
      else if (reg_rd)
         reg_rdata_ff <= nxt_rdata;
      else
         reg_rdata_ff <= `BRG_RST_BYTE;
   end

   // ----------------------------------------
   // rate timer
   // ----------------------------------------

   // prescaler gives one timer step every mult cycles; >= also catches
   // a mode change that lowers the multiplier mid count
   assign pre_end = (pre_ff >= mult - 7'h01);
   // narrow mode compares the low byte only
   assign timer_end = wide ? (timer_ff >= divisor) : (timer_ff[7:0] >= div_low_ff); // [RULE1] [RULE3]

   // prescaler
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         pre_ff <= 7'h00;
      else if (div_wr || pre_end)
         pre_ff <= 7'h00; // [RULE7]
      else
         pre_ff <= pre_ff + 7'h01;
   end

   // free-running counter, cleared by a divisor write
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         timer_ff <= 16'h0000;
      else if (div_wr)
         timer_ff <= 16'h0000; // [RULE7]
      else if (pre_end && timer_end)
         timer_ff <= 16'h0000; // [RULE12]
      else if (pre_end)
         timer_ff <= wide ? timer_ff + 16'h0001 : {8'h00, timer_ff[7:0] + 8'h01}; // [RULE2] [RULE3]
      else if (!wide)
         timer_ff[15:8] <= 8'h00; // a drop to narrow never leaves a stale high byte
   end

   // one-cycle tick; a divisor write suppresses the pending one
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         tick_ff <= 1'b0;
      else
         tick_ff <= !div_wr && pre_end && timer_end; // [RULE12]
   end

   // mode to the shift logic, registered
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         sync_mode <= 1'b0;
      else
         sync_mode <= sync;
   end

   assign reg_rdata = reg_rdata_ff;
   assign baud_tick = tick_ff;

   // ----------------------------------------
   // checks
   // ----------------------------------------

   // cycles since the last tick; valid only while nothing was written
   brg_span_t per_ff;
   logic valid_ff;
   brg_span_t span;
   assign span = 23'(mult) * 23'({1'b0, eff_div_f(wide, divisor)} + 17'h00001);

   // span counter restarts on every tick
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         per_ff <= 23'h000000;
      else if (tick_ff || div_wr)
         per_ff <= 23'h000001;
      else
         per_ff <= per_ff + 23'h000001;
   end

   // any write can change the period, so the measure restarts
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         valid_ff <= 1'b0;
      else if (reg_wr)
         valid_ff <= 1'b0;
      else if (tick_ff)
         valid_ff <= 1'b1;
   end

   a_async_period: assert property (@(posedge clk) disable iff (!rst_n) // [RULE5]
      tick_ff && valid_ff && !sync |-> per_ff == span)
      else $error("async tick period wrong");

   a_sync_period: assert property (@(posedge clk) disable iff (!rst_n) // [RULE8]
      tick_ff && valid_ff && sync |->
         per_ff == 23'(`BRG_MULT_FAST) * 23'({1'b0, eff_div_f(wide, divisor)} + 17'h00001))
      else $error("sync tick period wrong");

   a_hs_ignored: assert property (@(posedge clk) disable iff (!rst_n) // [RULE6]
      sync |-> pre_end == (pre_ff >= 7'h03))
      else $error("high speed select affects sync rate");

   a_write_clear: assert property (@(posedge clk) disable iff (!rst_n) // [RULE7]
      div_wr |=> timer_ff == 16'h0000 && pre_ff == 7'h00 && !tick_ff)
      else $error("divisor write did not clear timer");

   a_narrow_bound: assert property (@(posedge clk) disable iff (!rst_n) // [RULE2]
      !wide && $stable(wide) |-> timer_ff[15:8] == 8'h00)
      else $error("narrow timer uses high byte");

   a_wide_reach: assert property (@(posedge clk) disable iff (!rst_n) // [RULE3]
      wide && valid_ff && !reg_wr |-> timer_ff <= divisor)
      else $error("wide timer beyond divisor");

   a_single_tick: assert property (@(posedge clk) disable iff (!rst_n) // [RULE12]
      tick_ff |=> !tick_ff [*3])
      else $error("tick longer than one cycle");

   a_read_low: assert property (@(posedge clk) disable iff (!rst_n) // [RULE4]
      reg_rd && reg_addr == `BRG_OFF_DIV_LOW |=> reg_rdata == $past(div_low_ff) ##1 reg_rdata == 8'h00 || $past(reg_rd))
      else $error("divisor low read back wrong");

   a_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n) // [RULE4]
      !reg_rd |=> reg_rdata == 8'h00)
      else $error("read data seen without a read strobe");

   c_async_tick: cover property (@(posedge clk) disable iff (!rst_n) tick_ff && valid_ff && !sync && !wide);
   c_wide_tick: cover property (@(posedge clk) disable iff (!rst_n) tick_ff && valid_ff && wide && hs);
   c_sync_tick: cover property (@(posedge clk) disable iff (!rst_n) tick_ff && valid_ff && sync);
   c_restart: cover property (@(posedge clk) disable iff (!rst_n) div_wr && timer_ff != 16'h0000);

endmodule : brg_rate_gen

//--- testbench/brg_serial_model.sv
// far side: serial shift logic paced by the rate tick
// assumes: same clock and reset as the rate generator
`timescale 1ns/1ps

module brg_serial_model
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // from the rate generator
   input wire logic baud_tick,
   input wire logic sync_mode,
   // flags back to the rate generator
   output logic rx_idle,
   output logic tx_empty
);
   logic [3:0] tick_cnt_ff;

   // flags move only on ticks; in async mode receiver busy for half of every 16 bit times, never busy in sync mode
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tick_cnt_ff <= 4'h0;
         rx_idle <= 1'b1;
         tx_empty <= 1'b1;
      end
      else if (baud_tick) // one bit time per tick
      begin
         tick_cnt_ff <= tick_cnt_ff + 4'h1;
         rx_idle <= sync_mode | ~tick_cnt_ff[3];
         tx_empty <= ~tx_empty;
      end
   end
endmodule : brg_serial_model

//--- testbench/brg_rate_gen_test.sv
// bench for the rate generator, with a cycle model of the timer
// assumes: package and map header compiled first, serial model beside
`timescale 1ns/1ps
`include "brg_map.svh"

module brg_rate_gen_test
   import brg_pkg::*;
;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   brg_addr_t reg_addr = 3'h0;
   brg_byte_t reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   brg_byte_t reg_rdata;
   logic rx_idle, tx_empty, baud_tick, sync_mode;
   int error_cnt = 0;
   int check_count = 0;
   int since = 0; // cycles since the last divisor write
   int period = 0; // 0 while the timer phase is unknown
   int ticks = 0;
   bit [31:0] seed = 32'hDF3DD56E;
   brg_byte_t sh [5] = '{default: 8'h00};
   bit [10:0] c;
   // sync, wide, high speed, divisor high: all four async rows, two sync rows
   localparam bit [10:0] CFG [6] = '{{3'b000, 8'h05}, {3'b001, 8'h05}, {3'b010, 8'h01},
      {3'b011, 8'h00}, {3'b101, 8'h00}, {3'b110, 8'h00}};

   always #4 clk = ~clk;

   brg_rate_gen u_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_idle(rx_idle),
      .tx_empty(tx_empty), .baud_tick(baud_tick), .sync_mode(sync_mode));
   brg_serial_model u_far (.clk(clk), .rst_n(rst_n), .baud_tick(baud_tick),
      .sync_mode(sync_mode), .rx_idle(rx_idle), .tx_empty(tx_empty));

   // ----------------------------------------
   // compare and report
   // ----------------------------------------
   task automatic chk_byte(string what, brg_byte_t exp, brg_byte_t got);
      check_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("Error %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk_byte

   task automatic chk_bit(string what, logic exp, logic got);
      check_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("Error %s expected %0b seen %0b", what, exp, got);
      end
   endtask : chk_bit

   task automatic test_done();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : test_done

   // ----------------------------------------
   // model and bus
   // ----------------------------------------
   function automatic bit [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs

   // narrow width looks at the low byte only
   function automatic int period_of();
      int m;
      int n;
      m = sh[4][`BRG_BIT_SYNC] ? 4 : sh[0][`BRG_BIT_WIDE] ? (sh[4][`BRG_BIT_HSPEED] ? 4 : 16)
         : (sh[4][`BRG_BIT_HSPEED] ? 16 : 64);
      n = sh[0][`BRG_BIT_WIDE] ? {sh[3], sh[2]} : sh[2];
      return m * (n + 1);
   endfunction : period_of

   function automatic brg_byte_t reg_exp(int a);
      case (a)
         0: return sh[0] & `BRG_MASK_BAUD;
         4: return sh[4] & `BRG_MASK_TX;
         1, 2, 3: return sh[a];
         default: return 8'h00;
      endcase
   endfunction : reg_exp

   task automatic wr(int a, brg_byte_t d);
      reg_addr <= a[2:0];
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      if (a < 5)
         sh[a] = d;
      period = (a == 2 || a == 3) ? period_of() : 0;
      @(posedge clk); // let an edge pass before the next strobe
   endtask : wr

   // live flags are sampled at the edge that takes the read
   task automatic rd(int a, brg_byte_t exp);
      reg_addr <= a[2:0];
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      if (a == 0)
         exp[`BRG_BIT_RX_IDLE] = rx_idle;
      if (a == 4)
         exp[`BRG_BIT_TX_EMPTY] = tx_empty;
      @(posedge clk);
      chk_byte("reg_rdata", exp, reg_rdata);
   endtask : rd

   // timer phase restarts at the edge that takes a divisor write
   always @(posedge clk)
      since <= (reg_wr && (reg_addr == `BRG_OFF_DIV_LOW || reg_addr == `BRG_OFF_DIV_HIGH)) ? 0 : since + 1;

   always @(negedge clk)
      if (rst_n && period > 0)
      begin
         chk_bit("baud_tick", since > 0 && since % period == 0, baud_tick);
         ticks += baud_tick;
      end

   // hang guard
   initial
   begin
      #700000;
      error_cnt++;
      test_done();
   end

   initial
   begin
      repeat (3) @(posedge clk);
      chk_bit("baud_tick", 1'b0, baud_tick);
      chk_bit("sync_mode", 1'b0, sync_mode);
      rst_n <= 1'b1;
      @(posedge clk);
      for (int a = 0; a < 8; a++) rd(a, 8'h00);
      for (int a = 0; a < 8; a++) wr(a, 8'hFF);
      for (int a = 0; a < 8; a++) rd(a, reg_exp(a));
      $display("registers done");
      // every async width and speed choice, sync narrow with high speed and sync wide without
      foreach (CFG[i])
      begin
         c = CFG[i];
         wr(`BRG_OFF_BAUD_CTRL, {4'h0, c[9], 3'h0});
         wr(`BRG_OFF_TX_STAT, {3'h0, c[10], 1'b0, c[8], 2'h0});
         wr(`BRG_OFF_DIV_HIGH, c[7:0]);
         wr(`BRG_OFF_DIV_LOW, brg_byte_t'(xs() % 16));
         repeat (period - 2) @(posedge clk); // rewrite lands on the edge of the first tick
         wr(`BRG_OFF_DIV_LOW, sh[2]);
         ticks = 0;
         repeat (3 * period + 2) @(posedge clk);
         chk_byte("tick_count", 8'h03, ticks[7:0]);
         chk_bit("sync_mode", c[10], sync_mode);
         $display("rate row %0d done", i);
      end
      period = 0;
      // software waits for an idle receiver before disturbing the clock
      for (int k = 0; k < 400 && !rx_idle; k++) @(posedge clk);
      chk_bit("rx_idle", 1'b1, rx_idle);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      chk_bit("sync_mode", 1'b0, sync_mode);
      rst_n <= 1'b1;
      sh = '{default: 8'h00};
      @(posedge clk);
      rd(`BRG_OFF_BAUD_CTRL, 8'h00);
      rd(`BRG_OFF_TX_STAT, 8'h00);
      $display("second reset done");
      test_done();
   end
endmodule : brg_rate_gen_test
